// >>> pkg/sgx_defines.vh
// Purpose: Register map, field positions, reset values and timing for the
//          serial pin expander.
// Assumes: 32-bit register port, one word per register, 200 MHz clock.
// Notes:   Definitions only.
`ifndef SGX_DEFINES_VH
`define SGX_DEFINES_VH

// Register byte offsets
`define SGX_OFF_GENERAL 8'h00
`define SGX_OFF_CLOCK 8'h04
`define SGX_OFF_PORT_ENA 8'h08
`define SGX_OFF_STATUS 8'h0c
`define SGX_OFF_CAPTURE 8'h10
`define SGX_OFF_OUTVAL 8'h20

// general_config field positions
`define SGX_GC_ONE_BURST 0
`define SGX_GC_REPEAT 1
`define SGX_GC_BPP_LO 2
`define SGX_GC_REV_IN 4
`define SGX_GC_REV_OUT 5
`define SGX_GC_LOAD_POL 6
`define SGX_GC_GAP_DIS 7
`define SGX_GC_GAP_LO 8

// Reset values
`define SGX_RST_BPP 2'h3
`define SGX_RST_LOAD_POL 1'h1
`define SGX_RST_GAP 6'h01
`define SGX_RST_RATE 8'h09
`define SGX_RST_PORT_ENA 32'hffffffff

// Timing
`define SGX_CLK_MHZ 200
`define SGX_LOAD_NS 25
`define SGX_LOAD_CYC ((`SGX_LOAD_NS * `SGX_CLK_MHZ + 999) / 1000)
`define SGX_GAP_STEP_US 1000
`define SGX_GAP_STEP_CYC (`SGX_GAP_STEP_US * `SGX_CLK_MHZ)

`endif

// >>> design/sgx_pin_sync.v
// Purpose: Three-stage synchroniser for the serial data input pin.
// Assumes: Pin is asynchronous to clock.
// Notes:   Output moves only when stages two and three agree.
`timescale 1ns/1ps
module sgx_pin_sync (
    input wire clock,
    input wire rstN,
    input wire pinIn,
    output reg pinOut
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // First stage feeds only the second, to contain metastability
    always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            pinOut <= 1'b0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                pinOut <= s3_q;
            end
        end
    end
endmodule

// >>> design/sgx_rate_div.v
// Purpose: Enable pulses for shift-clock half periods and burst gap steps.
// Assumes: Single clock; pulses are one cycle long.
// Notes:   Half-period counter restarts whenever run is low.
`timescale 1ns/1ps
module sgx_rate_div #(
    parameter STEP_CYC = 200000
) (
    input wire clock,
    input wire rstN,
    input wire run,
    input wire [7:0] rate,
    output reg halfTick,
    output reg stepTick
);
    reg [7:0] half_q;
    reg [31:0] step_q;

    // Half period lasts rate+1 clocks
    always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            half_q <= 8'h00;
            halfTick <= 1'b0;
        end else if (!run) begin
            half_q <= 8'h00;
            halfTick <= 1'b0;
        end else if (half_q >= rate) begin
            half_q <= 8'h00;
            halfTick <= 1'b1;
        end else begin
            half_q <= half_q + 8'h01;
            halfTick <= 1'b0;
        end
    end

    // Free running gap step, about one millisecond
    always @(posedge clock or negedge rstN) begin
        if (!rstN) begin
            step_q <= 32'h00000000;
            stepTick <= 1'b0;
        end else if (step_q >= STEP_CYC - 1) begin
            step_q <= 32'h00000000;
            stepTick <= 1'b1;
        end else begin
            step_q <= step_q + 32'h00000001;
            stepTick <= 1'b0;
        end
    end
endmodule

// >>> design/sgx_expander.v
// Purpose: Serial pin expander: shifts up to 128 serial pins through an
//          external shift register chain and captures the returned bits.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes:   Serial data in is asynchronous and is synchronised here.
//
// Behaviour
// - Up to 128 serial pins, as 32 ports of four pins.
// - Shift pin values out, then pulse load strobe after the last bit.
// - Sample serial data in while shifting; software reads captured inputs.
// - Ports with clear enable bit are skipped in the stream entirely.
// - Bits per port selects 1 to 4 pins, common to all ports.
// - Unused pin positions inside a port are skipped like disabled ports.
// - Enable mask and bits per port govern both streams alike.
// - Each pin position is driven and captured in the same slot when both order flags match.
// - Bursts end with a load strobe; at most 128 data cycles each.
// - Gap between repeated bursts in about 1 ms steps, or none.
// - One burst request runs one burst; hardware clears it after.
// - Repeat bursts continues until software clears the bit.
// - Shift clock rate field sets the shift clock frequency.
// - Load strobe pulse lasts 25 ns to 30 ns after each burst.
// - Load polarity bit sets the active level of the load strobe.
// - Input and output port order reverse independently.
// - Per-pin output value select sets each driven pin value.
`timescale 1ns/1ps
`include "sgx_defines.vh"
module sgx_expander #(
    parameter GAP_STEP_CYC = `SGX_GAP_STEP_CYC,
    parameter PORTS = 32,
    parameter PINS = 4
) (
    input wire clock,
    input wire nrst,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wrStb,
    input wire rdStb,
    output reg [31:0] rdata,
    output reg shiftClockOut,
    output reg serialDataOut,
    input wire serialDataIn,
    output reg loadStrobe
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SEEK = 3'h1;
    localparam ST_LOW = 3'h2;
    localparam ST_HIGH = 3'h3;
    localparam ST_LOAD = 3'h4;
    localparam ST_GAP = 3'h5;
    localparam integer LOAD_CYC_INT = `SGX_LOAD_CYC;
    localparam [3:0] LOAD_CYC = LOAD_CYC_INT[3:0];

    // Port index in the chosen direction
    function [4:0] portOf;
        input [5:0] cnt;
        input rev;
        begin
            portOf = rev ? ~cnt[4:0] : cnt[4:0];
        end
    endfunction

    // Flat pin index: word per pin position, bit per port
    function [6:0] pinIdx;
        input [1:0] bitPos;
        input [4:0] port;
        begin
            pinIdx = {bitPos, port};
        end
    endfunction

    reg rstA_q;
    reg rstN_q;
    wire dinSync;
    wire halfTick;
    wire stepTick;

    // Configuration registers
    reg oneBurst_q;
    reg repeat_q;
    reg [1:0] bitsPerPort_q;
    reg revIn_q;
    reg revOut_q;
    reg loadPol_q;
    reg gapDis_q;
    reg [5:0] gapLen_q;
    reg [7:0] rate_q;
    reg [31:0] portEna_q;
    reg [PORTS*PINS-1:0] outVal_q;
    reg [PORTS*PINS-1:0] capture_q;

    // Engine state
    reg [2:0] state_q;
    reg [5:0] outCnt_q;
    reg [5:0] inCnt_q;
    reg [1:0] bit_q;
    reg [3:0] loadCnt_q;
    reg [5:0] gapCnt_q;
    reg loadOn_q;
    reg [7:0] burstCnt_q;

    wire [4:0] outPort;
    wire [4:0] inPort;
    wire wrGeneral;
    wire burstEnd;
    wire running;

    assign outPort = portOf(outCnt_q, revOut_q);
    assign inPort = portOf(inCnt_q, revIn_q);
    assign wrGeneral = wrStb && (addr == `SGX_OFF_GENERAL);
    assign burstEnd = (state_q == ST_LOAD) && (loadCnt_q == LOAD_CYC);
    assign running = (state_q == ST_LOW) || (state_q == ST_HIGH);

    // Reset released through two flops; assertion stays asynchronous
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rstA_q <= 1'b0;
            rstN_q <= 1'b0;
        end else begin
            rstA_q <= 1'b1;
            rstN_q <= rstA_q;
        end
    end

    sgx_pin_sync uSync (
        .clock(clock),
        .rstN(rstN_q),
        .pinIn(serialDataIn),
        .pinOut(dinSync)
    );

    sgx_rate_div #(
        .STEP_CYC(GAP_STEP_CYC)
    ) uDiv (
        .clock(clock),
        .rstN(rstN_q),
        .run(running),
        .rate(rate_q),
        .halfTick(halfTick),
        .stepTick(stepTick)
    );

    // Software configuration writes
    always @(posedge clock or negedge rstN_q) begin
        if (!rstN_q) begin
            repeat_q <= 1'b0;
            bitsPerPort_q <= `SGX_RST_BPP;
            revIn_q <= 1'b0;
            revOut_q <= 1'b0;
            loadPol_q <= `SGX_RST_LOAD_POL;
            gapDis_q <= 1'b0;
            gapLen_q <= `SGX_RST_GAP;
            rate_q <= `SGX_RST_RATE;
            portEna_q <= `SGX_RST_PORT_ENA;
        end else if (wrStb) begin
            case (addr)
                `SGX_OFF_GENERAL: begin
                    repeat_q <= wdata[`SGX_GC_REPEAT];
                    bitsPerPort_q <= wdata[`SGX_GC_BPP_LO+1:`SGX_GC_BPP_LO];
                    revIn_q <= wdata[`SGX_GC_REV_IN];
                    revOut_q <= wdata[`SGX_GC_REV_OUT];
                    loadPol_q <= wdata[`SGX_GC_LOAD_POL];
                    gapDis_q <= wdata[`SGX_GC_GAP_DIS];
                    gapLen_q <= wdata[`SGX_GC_GAP_LO+5:`SGX_GC_GAP_LO];
                end
                `SGX_OFF_CLOCK: begin
                    rate_q <= wdata[7:0];
                end
                `SGX_OFF_PORT_ENA: begin
                    portEna_q <= wdata;
                end
                default: begin
                    rate_q <= rate_q;
                end
            endcase
        end
    end

    // One burst request: a software set wins over the hardware clear
    always @(posedge clock or negedge rstN_q) begin
        if (!rstN_q) begin
            oneBurst_q <= 1'b0;
        end else if (wrGeneral && wdata[`SGX_GC_ONE_BURST]) begin
            oneBurst_q <= 1'b1;
        end else if (burstEnd) begin
            oneBurst_q <= 1'b0;
        end
    end

    // Output value select words, one word per pin position
    genvar w;
    generate
        for (w = 0; w < PINS; w = w + 1) begin : gOutVal
            // Word offset cut to the address width on purpose
            localparam integer WORD_OFF = `SGX_OFF_OUTVAL + 4 * w;
            always @(posedge clock or negedge rstN_q) begin
                if (!rstN_q) begin
                    outVal_q[w*PORTS +: PORTS] <= {PORTS{1'b0}};
                end else if (wrStb && (addr == WORD_OFF[7:0])) begin
                    outVal_q[w*PORTS +: PORTS] <= wdata;
                end
            end
        end
    endgenerate

    // Read data, valid only in the cycle after the strobe
    always @(posedge clock or negedge rstN_q) begin
        if (!rstN_q) begin
            rdata <= 32'h00000000;
        end else if (rdStb) begin
            case (addr)
                `SGX_OFF_GENERAL: begin
                    rdata <= {18'h00000, gapLen_q, gapDis_q, loadPol_q, revOut_q,
                        revIn_q, bitsPerPort_q, repeat_q, oneBurst_q};
                end
                `SGX_OFF_CLOCK: begin
                    rdata <= {24'h000000, rate_q};
                end
                `SGX_OFF_PORT_ENA: begin
                    rdata <= portEna_q;
                end
                `SGX_OFF_STATUS: begin
                    rdata <= {21'h000000, state_q, burstCnt_q};
                end
                `SGX_OFF_CAPTURE: begin
                    rdata <= capture_q[31:0];
                end
                `SGX_OFF_CAPTURE + 8'h04: begin
                    rdata <= capture_q[63:32];
                end
                `SGX_OFF_CAPTURE + 8'h08: begin
                    rdata <= capture_q[95:64];
                end
                `SGX_OFF_CAPTURE + 8'h0c: begin
                    rdata <= capture_q[127:96];
                end
                `SGX_OFF_OUTVAL: begin
                    rdata <= outVal_q[31:0];
                end
                `SGX_OFF_OUTVAL + 8'h04: begin
                    rdata <= outVal_q[63:32];
                end
                `SGX_OFF_OUTVAL + 8'h08: begin
                    rdata <= outVal_q[95:64];
                end
                `SGX_OFF_OUTVAL + 8'h0c: begin
                    rdata <= outVal_q[127:96];
                end
                default: begin
                    rdata <= 32'h00000000;
                end
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    // Burst engine. Skipped slots cost one system clock and no shift clock.
    // Both pointers walk the same enabled set, so streams stay the same length.
    always @(posedge clock or negedge rstN_q) begin
        if (!rstN_q) begin
            state_q <= ST_IDLE;
            outCnt_q <= 6'h00;
            inCnt_q <= 6'h00;
            bit_q <= 2'h0;
            loadCnt_q <= 4'h0;
            gapCnt_q <= 6'h00;
            loadOn_q <= 1'b0;
            shiftClockOut <= 1'b0;
            serialDataOut <= 1'b0;
            capture_q <= {PORTS*PINS{1'b0}};
            burstCnt_q <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (oneBurst_q || repeat_q) begin
                        state_q <= ST_SEEK;
                        outCnt_q <= 6'h00;
                        inCnt_q <= 6'h00;
                        bit_q <= 2'h0;
                    end
                end
                ST_SEEK: begin
                    if (outCnt_q[5]) begin
                        // Chain done: at most 32 x 4 data cycles
                        state_q <= ST_LOAD;
                        loadOn_q <= 1'b1;
                        loadCnt_q <= 4'h1;
                    end else if (!portEna_q[outPort]) begin
                        outCnt_q <= outCnt_q + 6'h01;
                    end else if (!inCnt_q[5] && !portEna_q[inPort]) begin
                        inCnt_q <= inCnt_q + 6'h01;
                    end else begin
                        // Present the pin value while the clock is low
                        serialDataOut <= outVal_q[pinIdx(bit_q, outPort)];
                        state_q <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (halfTick) begin
                        // Rising edge: capture the same slot's input
                        shiftClockOut <= 1'b1;
                        capture_q[pinIdx(bit_q, inPort)] <= dinSync;
                        state_q <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (halfTick) begin
                        shiftClockOut <= 1'b0;
                        state_q <= ST_SEEK;
                        if (bit_q == bitsPerPort_q) begin
                            // Unused positions skipped like disabled ports
                            bit_q <= 2'h0;
                            outCnt_q <= outCnt_q + 6'h01;
                            inCnt_q <= inCnt_q + 6'h01;
                        end else begin
                            bit_q <= bit_q + 2'h1;
                        end
                    end
                end
                ST_LOAD: begin
                    if (loadCnt_q == LOAD_CYC) begin
                        // Pulse held exactly LOAD_CYC clocks
                        loadOn_q <= 1'b0;
                        burstCnt_q <= burstCnt_q + 8'h01;
                        gapCnt_q <= gapDis_q ? 6'h00 : gapLen_q;
                        state_q <= repeat_q ? ST_GAP : ST_IDLE;
                    end else begin
                        loadCnt_q <= loadCnt_q + 4'h1;
                    end
                end
                ST_GAP: begin
                    if (gapCnt_q == 6'h00) begin
                        // Repeat cleared during the gap ends the series
                        state_q <= repeat_q ? ST_SEEK : ST_IDLE;
                        outCnt_q <= 6'h00;
                        inCnt_q <= 6'h00;
                        bit_q <= 2'h0;
                    end else if (stepTick) begin
                        gapCnt_q <= gapCnt_q - 6'h01;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Load pin level follows polarity even when idle; one flop of delay
    // keeps the pulse width unchanged.
    always @(posedge clock or negedge rstN_q) begin
        if (!rstN_q) begin
            loadStrobe <= ~`SGX_RST_LOAD_POL;
        end else begin
            loadStrobe <= loadOn_q ? loadPol_q : ~loadPol_q;
        end
    end
endmodule

// >>> bench/sgx_expander_chk.sv
// Purpose: Port-level temporal checks for the serial pin expander.
// Assumes: Bench sets rate 7, so the shift clock high phase is 8 clocks and the low phase at least 10.
// Notes:   Load activity is judged from a mirror of the polarity bit;
//          the load width check pauses briefly after config writes, as the idle level may flip.
`timescale 1ns/1ps
module sgx_expander_chk #(
    parameter GAP_STEP_CYC = 200000,
    parameter PORTS = 32,
    parameter PINS = 4
) (
    input wire clock,
    input wire nrst,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wrStb,
    input wire rdStb,
    input wire [31:0] rdata,
    input wire shiftClockOut,
    input wire serialDataOut,
    input wire serialDataIn,
    input wire loadStrobe
);
    reg pol_q;
    reg [2:0] cfgWr_q;
    reg [7:0] rises_q;
    wire cfgWr = wrStb && (addr == 8'h00);
    wire loadActive = (loadStrobe == pol_q);

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Polarity mirror, recent config writes, shift pulses since last load
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pol_q <= 1'b1;
            cfgWr_q <= 3'h0;
            rises_q <= 8'h00;
        end else begin
            if (cfgWr)
                pol_q <= wdata[6];
            cfgWr_q <= {cfgWr_q[1:0], cfgWr};
            if (loadActive)
                rises_q <= 8'h00;
            else if ($rose(shiftClockOut))
                rises_q <= rises_q + 8'h01;
        end
    end

    sequence s_shot;
        cfgWr && wdata[0];
    endsequence
    sequence s_loadStart;
        $rose(loadActive);
    endsequence

    a_clk_high:
        assert property ($rose(shiftClockOut) |-> shiftClockOut[*8] ##1 !shiftClockOut)
        else $error("shift clock high phase is not eight cycles");
    a_clk_low:
        assert property ($fell(shiftClockOut) |-> !shiftClockOut[*8])
        else $error("shift clock low phase shorter than eight cycles");
    a_dout_stable:
        assert property (shiftClockOut |-> $stable(serialDataOut))
        else $error("serial data moved while shift clock high");
    a_load_width:
        assert property (disable iff (!nrst || cfgWr_q != 3'h0)
            s_loadStart |-> loadActive[*5] ##1 !loadActive)
        else $error("load pulse not five cycles long");
    a_load_no_clk:
        assert property (loadActive |-> !shiftClockOut)
        else $error("shift clock high during load");
    a_burst_cap:
        assert property (rises_q <= PORTS * PINS)
        else $error("burst longer than the pin count");
    a_shot_load:
        assert property (s_shot |-> ##[1:1000] s_loadStart)
        else $error("one burst request gave no load pulse");
    a_rdata_idle:
        assert property (!$past(rdStb) |-> rdata == 32'h0)
        else $error("read data outside its answer cycle");
    a_wr_rd:
        assert property (wrStb && addr == 8'h08 ##2 rdStb && addr == 8'h08 |=> rdata == $past(wdata))
        else $error("port enable readback differs from write");
endmodule

bind sgx_expander sgx_expander_chk #(.GAP_STEP_CYC(GAP_STEP_CYC), .PORTS(PORTS), .PINS(PINS)) chk (
    .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb),
    .rdata(rdata), .shiftClockOut(shiftClockOut), .serialDataOut(serialDataOut),
    .serialDataIn(serialDataIn), .loadStrobe(loadStrobe));

// >>> bench/sgx_chain_model.sv
// Purpose: Board-side chain of shift registers on the serial pin link.
// Assumes: Load pin low loads inputs; its rising edge updates outputs.
// Notes:   Unloaded input stages start with an alternating pattern, so stale data shows.
`timescale 1ns/1ps
module sgx_chain_model (
    input wire shiftClk,
    input wire dIn,
    input wire ld,
    input wire [7:0] stages,
    input wire [127:0] inVals,
    output logic dOut,
    output logic [127:0] outVals,
    output int burstLen,
    output int nBurst
);
    logic [127:0] sipo;
    logic [127:0] piso;
    int nRise;
    int i;
    assign dOut = piso[0];
    initial begin
        sipo = '0;
        piso = {64{2'b01}};
        outVals = '0;
        nRise = 0;
        burstLen = 0;
        nBurst = 0;
    end
    // Chain length is the stage count set by the bench
    always @(posedge shiftClk) begin
        sipo <= {sipo[126:0], dIn};
        nRise <= nRise + 1;
        if (ld)
            piso <= piso >> 1; // Input side shifts only while load high
    end
    // Load low grabs board inputs, so a fresh sample needs a second burst
    always @(negedge ld) begin
        piso <= inVals;
        burstLen <= nRise;
        nRise <= 0;
        nBurst <= nBurst + 1;
    end
    // Outputs change only on the rising load edge
    always @(posedge ld) begin
        for (i = 0; i < stages; i++)
            outVals[i] <= sipo[stages - 1 - i];
    end
endmodule

// >>> bench/sgx_expander_test.sv
// Purpose: Self-checking bench for the serial pin expander.
// Assumes: Chain model on the link pins; active-low load whenever inputs are read.
// Notes:   Gap step shortened to 20 clocks to keep the run short.
`timescale 1ns/1ps
module sgx_expander_test;
    localparam logic [31:0] MASK = 32'h80000005;
    logic clock, nrst, wrStb, rdStb, shiftClockOut, serialDataOut, serialDataIn, loadStrobe;
    logic [7:0] addr, stg;
    logic [31:0] wdata, rdata, eo;
    logic [127:0] inVals, chOut;
    logic [31:0] ov [4];
    logic [31:0] cap [4];
    int miscompares, checks, cyc, chLen, chBursts;

    sgx_expander #(.GAP_STEP_CYC(20)) uut (.clock(clock), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
        .shiftClockOut(shiftClockOut), .serialDataOut(serialDataOut),
        .serialDataIn(serialDataIn), .loadStrobe(loadStrobe));
    sgx_chain_model chain (.shiftClk(shiftClockOut), .dIn(serialDataOut), .ld(loadStrobe),
        .stages(stg), .inVals(inVals), .dOut(serialDataIn), .outVals(chOut),
        .burstLen(chLen), .nBurst(chBursts));

    // 200 MHz system clock
    initial clock = 1'b0;
    always #2.5 clock = ~clock;
    // Cycle count for gap measurement
    always @(posedge clock) cyc <= cyc + 1;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wrStb <= 1'b1;
        @(posedge clock);
        wrStb <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clock);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clock);
        rdStb <= 1'b0;
        #1;
        chk(rdata & m, e & m);
    endtask
    // One-shot burst, waits for the active-low load pulse to end
    task burst(input logic [31:0] v);
        int i;
        wr(8'h00, v);
        for (i = 0; i < 2000 && loadStrobe !== 1'b0; i++) @(posedge clock);
        for (i = 0; i < 50 && loadStrobe !== 1'b1; i++) @(posedge clock);
    endtask
    // Cycles between two successive load pulses
    task period(output int t);
        int n;
        int t0;
        n = chBursts;
        wait (chBursts != n);
        t0 = cyc;
        n = chBursts;
        wait (chBursts != n);
        t = cyc - t0;
    endtask
    task end_of_test;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Watchdog: the run needs under 10000 cycles
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end

    initial begin
        int c, k, j, q, po, pi, no, ni, t0, t2, n;
        logic [31:0] v;
        nrst = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wrStb = 1'b0;
        rdStb = 1'b0;
        stg = 8'd12;
        inVals = {4{32'h3c5a96e1}};
        cyc = 0;
        miscompares = 0;
        checks = 0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        repeat (3) @(posedge clock);
        // Reset values, read-only status, unmapped place
        rd(8'h00, 32'h0000014c, '1);
        rd(8'h04, 32'h9, '1);
        rd(8'h08, 32'hffffffff, '1);
        chk({31'h0, loadStrobe}, 32'h0);
        wr(8'h0c, 32'hffffffff);
        rd(8'h0c, 32'h0, '1);
        wr(8'h40, 32'hffffffff);
        rd(8'h40, 32'h0, '1);
        wr(8'h08, MASK);
        rd(8'h08, MASK, '1);
        wr(8'h04, 32'h7);
        wr(8'h00, 32'h0000008c);
        repeat (3) @(posedge clock);
        chk({31'h0, loadStrobe}, 32'h1);
        // Every width and both order flags, two bursts each
        for (c = 0; c < 4; c++) begin
            v = 32'h81 | (c << 2) | ((c & 2) << 3) | ((c & 1) << 5);
            stg <= 8'(3 * (c + 1));
            inVals <= {4{32'h3c5a96e1}} >> (3 * c + 1);
            for (k = 0; k < 4; k++) begin
                ov[k] = 32'h6d2b79f4 >> (k + c);
                wr(8'h20 + 8'(4 * k), ov[k]);
            end
            burst(v);
            burst(v);
            no = 0;
            ni = 0;
            eo = 32'h0;
            for (q = 0; q < 32; q++) begin
                po = c[0] ? 31 - q : q;
                pi = c[1] ? 31 - q : q;
                for (j = 0; j <= c; j++) begin
                    if (MASK[po]) begin
                        eo[no] = ov[j][po];
                        no++;
                    end
                    if (MASK[pi]) begin
                        cap[j][pi] = inVals[ni];
                        ni++;
                    end
                end
            end
            chk(chOut[31:0], eo);
            chk(chLen, 3 * (c + 1));
            for (j = 0; j <= c; j++)
                rd(8'h10 + 8'(4 * j), cap[j], MASK);
            rd(8'h00, v & ~32'h1, '1);
        end
        // Repeated bursts: two-step gap against none, then stop
        stg <= 8'd1;
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h00000202);
        period(t2);
        period(t2);
        wr(8'h00, 32'h00000282);
        period(t0);
        period(t0);
        chk({31'h0, t2 - t0 >= 20 && t2 - t0 <= 41}, 32'h1);
        wr(8'h00, 32'h00000080);
        repeat (200) @(posedge clock);
        n = chBursts;
        repeat (400) @(posedge clock);
        chk(chBursts, n);
        end_of_test();
    end
endmodule
